// >>> agmb_pkg.sv
// Purpose: Shared constants and types for the modulo and bit-reversed address generator.
// Assumes: 16-bit data addresses and sixteen working registers.
// Notes: Mode encodings are internal to this block.
package agmb_pkg;
   localparam int ADDR_W = 16;
   localparam int WSEL_W = 4;
   localparam logic [WSEL_W-1:0] STACK_SEL = 4'hF;
   localparam logic [ADDR_W-1:0] ZERO_ADDR = 16'h0000;
   localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
   localparam logic [ADDR_W-1:0] BYTE_STEP = 16'h0001;
   typedef enum logic [2:0] {
      AGMB_DIRECT = 3'b000,
      AGMB_PRE_INC = 3'b001,
      AGMB_POST_INC = 3'b010,
      AGMB_PRE_DEC = 3'b011,
      AGMB_POST_DEC = 3'b100,
      AGMB_BASE_OFS = 3'b101
   } agmb_mode_t;
endpackage

// >>> agmb_bitrev_add.sv
// Purpose: Adds a pointer to a bit-order-reversed modifier.
// Assumes: Word-sized data, so the result least significant bit is cleared.
// Notes: Reverse-carry addition equals reversing, adding and reversing back.
`timescale 1ns/1ps
`default_nettype none
module agmb_bitrev_add #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] ptr_i,
   input wire logic [WIDTH-1:0] mod_i,
   output logic [WIDTH-1:0] sum_o
);
   logic [WIDTH-1:0] ptr_rev;
   logic [WIDTH-1:0] mod_rev;
   logic [WIDTH-1:0] sum_rev;
   genvar g;
   for (g = 0; g < WIDTH; g++) begin : g_rev
      // Both pointer and modifier are bit-reversed; the sum is reversed back to normal order.
      assign ptr_rev[g] = ptr_i[WIDTH-1-g];
      assign mod_rev[g] = mod_i[WIDTH-1-g];
      assign sum_o[WIDTH-1-g] = (g == WIDTH - 1) ? 1'b0 : sum_rev[g];
   end
   // The reversed pointer is added to the reversed modifier and the least significant bit is forced low.
   assign sum_rev = WIDTH'(ptr_rev + mod_rev);
endmodule
`default_nettype wire

// >>> agmb_top.sv
// Functional notes
// - Circular correction may use any working register as pointer.
// - Incrementing buffer: compare address against the upper boundary.
// - Decrementing buffer: compare address against the lower boundary.
// - Boundary test catches overshoot, not only equality, and wraps correctly.
// - Corrected address written back only for pre- or post-modify forms.
// - Base plus offset form corrects the access but leaves base unchanged.
// - Bit reversal only on the X unit and only for data writes.
// - The modifier is treated with reversed bit order.
// - Source and destination addresses stay in normal bit order.
// - Bit reversal needs non-stack select, enable set, and pre/post increment.
// - Bit reversal adds pointer to reversed modifier, ignores offset, clears bit zero.
// - Byte writes or other modes give normal addresses despite enable.
// Purpose: Effective address generator with modulo and bit-reversed correction.
// Assumes: Request and result are on the core clock; one request per cycle.
// Notes: Outputs are registered one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module agmb_top
   import agmb_pkg::*;
#(
   parameter int AW = agmb_pkg::ADDR_W
) (
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   input wire logic REQ_VALID_I,
   input wire logic [agmb_pkg::WSEL_W-1:0] REQ_WSEL_I,
   input wire agmb_pkg::agmb_mode_t REQ_MODE_I,
   input wire logic [AW-1:0] REQ_WREG_I,
   input wire logic [AW-1:0] REQ_OFFSET_I,
   input wire logic REQ_BYTE_I,
   input wire logic REQ_WRITE_I,
   input wire logic REQ_XAGU_I,
   input wire logic MOD_ENABLE_I,
   input wire logic [agmb_pkg::WSEL_W-1:0] MOD_WSEL_I,
   input wire logic [AW-1:0] MOD_START_I,
   input wire logic [AW-1:0] MOD_END_I,
   input wire logic BITREV_ENABLE_BIT_I,
   input wire logic [agmb_pkg::WSEL_W-1:0] BITREV_POINTER_SELECT_I,
   input wire logic [AW-1:0] BITREV_MODIFIER_VALUE_I,
   output logic ADDR_VALID_O,
   output logic [AW-1:0] EFFECTIVE_ADDRESS_O,
   output logic WB_VALID_O,
   output logic [agmb_pkg::WSEL_W-1:0] WB_WSEL_O,
   output logic [AW-1:0] WB_DATA_O,
   output logic BITREV_USED_O,
   output logic MOD_WRAP_O
);
   import agmb_pkg::*;

   logic [AW-1:0] step;
   logic is_pre;
   logic is_post;
   logic is_inc;
   logic is_dec;
   logic is_modify;
   logic [AW-1:0] updated;
   logic [AW-1:0] access_raw;
   logic [AW-1:0] buf_len;
   logic mod_hit;
   logic over_up;
   logic under_lo;
   logic [AW-1:0] acc_fix;
   logic [AW-1:0] upd_fix;
   logic brev_on;
   logic [AW-1:0] brev_sum;
   logic [AW-1:0] next_addr;
   logic [AW-1:0] next_wb;
   logic next_wb_valid;

   assign step = REQ_BYTE_I ? BYTE_STEP : WORD_STEP;
   assign is_pre = (REQ_MODE_I == AGMB_PRE_INC) || (REQ_MODE_I == AGMB_PRE_DEC);
   assign is_post = (REQ_MODE_I == AGMB_POST_INC) || (REQ_MODE_I == AGMB_POST_DEC);
   assign is_inc = (REQ_MODE_I == AGMB_PRE_INC) || (REQ_MODE_I == AGMB_POST_INC);
   assign is_dec = (REQ_MODE_I == AGMB_PRE_DEC) || (REQ_MODE_I == AGMB_POST_DEC);
   assign is_modify = is_pre || is_post;
   assign updated = is_inc ? AW'(REQ_WREG_I + step)
                  : is_dec ? AW'(REQ_WREG_I - step) : REQ_WREG_I;
   assign access_raw = (REQ_MODE_I == AGMB_BASE_OFS) ? AW'(REQ_WREG_I + REQ_OFFSET_I)
                     : is_pre ? updated : REQ_WREG_I;
   assign buf_len = AW'(MOD_END_I - MOD_START_I + BYTE_STEP);

   // Any working register can be the circular pointer.
   assign mod_hit = MOD_ENABLE_I && (REQ_WSEL_I == MOD_WSEL_I);

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] a, input logic up,
                                          input logic [AW-1:0] lo, input logic [AW-1:0] hi,
                                          input logic [AW-1:0] len);
      logic [AW-1:0] r;
      r = a;
      // Strictly beyond the boundary, wrapped by length so the overshoot is kept.
      if (up && (a > hi)) begin
         r = AW'(a - len);
      end else if (!up && (a < lo)) begin
         r = AW'(a + len);
      end
      return r;
   endfunction

   // Incrementing checks the upper boundary, decrementing the lower one.
   assign over_up = mod_hit && !is_dec && (access_raw > MOD_END_I || updated > MOD_END_I);
   assign under_lo = mod_hit && is_dec && (access_raw < MOD_START_I || updated < MOD_START_I);
   assign acc_fix = mod_hit ? wrap(access_raw, !is_dec, MOD_START_I, MOD_END_I, buf_len)
                  : access_raw;
   assign upd_fix = mod_hit ? wrap(updated, !is_dec, MOD_START_I, MOD_END_I, buf_len)
                  : updated;

   // Reversal needs X unit, word write, non-stack select, enable and increment form.
   assign brev_on = BITREV_ENABLE_BIT_I && (BITREV_POINTER_SELECT_I != STACK_SEL)
                  && (REQ_WSEL_I == BITREV_POINTER_SELECT_I) && is_inc
                  && REQ_XAGU_I && REQ_WRITE_I && !REQ_BYTE_I;

   agmb_bitrev_add #(.WIDTH(AW)) u_brev (
      .ptr_i(REQ_WREG_I),
      .mod_i(BITREV_MODIFIER_VALUE_I),
      .sum_o(brev_sum)
   );

   // Bit reversal takes precedence over circular correction for writes.
   assign next_addr = brev_on ? ((REQ_MODE_I == AGMB_PRE_INC) ? brev_sum : REQ_WREG_I)
                    : acc_fix;
   // Only the modify forms write back; base plus offset keeps the base.
   assign next_wb_valid = REQ_VALID_I && is_modify;
   assign next_wb = brev_on ? brev_sum : upd_fix;

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         ADDR_VALID_O <= 1'b0;
         WB_VALID_O <= 1'b0;
      end else begin
         ADDR_VALID_O <= REQ_VALID_I;
         WB_VALID_O <= next_wb_valid;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         EFFECTIVE_ADDRESS_O <= ZERO_ADDR;
         WB_WSEL_O <= '0;
         WB_DATA_O <= ZERO_ADDR;
      end else begin
         EFFECTIVE_ADDRESS_O <= next_addr;
         WB_WSEL_O <= REQ_WSEL_I;
         WB_DATA_O <= next_wb;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         BITREV_USED_O <= 1'b0;
         MOD_WRAP_O <= 1'b0;
      end else begin
         BITREV_USED_O <= REQ_VALID_I && brev_on;
         MOD_WRAP_O <= REQ_VALID_I && !brev_on && (over_up || under_lo);
      end
   end

   a_wb_only_modify: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      WB_VALID_O |-> $past(is_modify) && $past(REQ_VALID_I))
      else $error("Write-back without a modify form.");
   a_base_ofs_nowb: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && REQ_MODE_I == AGMB_BASE_OFS |=> !WB_VALID_O && ADDR_VALID_O)
      else $error("Base plus offset wrote the base register.");
   a_brev_write_only: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      BITREV_USED_O |-> $past(REQ_WRITE_I) && $past(REQ_XAGU_I))
      else $error("Bit reversal on a read or non-X access.");
   a_brev_lsb_clear: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      BITREV_USED_O |-> !WB_DATA_O[0])
      else $error("Bit-reversed address has bit zero set.");
   a_brev_no_stack: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && BITREV_POINTER_SELECT_I == STACK_SEL |=> !BITREV_USED_O)
      else $error("Bit reversal used on stack select.");
   a_brev_no_byte: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && REQ_BYTE_I |=> !BITREV_USED_O)
      else $error("Bit reversal used for a byte write.");
   a_up_in_range: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && mod_hit && is_inc && !brev_on && REQ_WREG_I <= MOD_END_I
      && REQ_WREG_I >= MOD_START_I && MOD_END_I < ~WORD_STEP |=> WB_DATA_O <= MOD_END_I)
      else $error("Incrementing pointer left the buffer.");
   a_dn_in_range: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && mod_hit && is_dec && !brev_on && REQ_WREG_I >= MOD_START_I
      && REQ_WREG_I <= MOD_END_I && MOD_START_I > WORD_STEP |=> WB_DATA_O >= MOD_START_I)
      else $error("Decrementing pointer left the buffer.");
   a_any_wreg: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      MOD_WRAP_O |-> $past(REQ_WSEL_I) == $past(MOD_WSEL_I))
      else $error("Wrap reported for an unselected register.");
   a_brev_needs_en: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      BITREV_USED_O |-> $past(BITREV_ENABLE_BIT_I) && $past(is_inc))
      else $error("Bit reversal without enable or increment form.");
   a_brev_pre_addr: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      BITREV_USED_O && $past(REQ_MODE_I) == AGMB_PRE_INC |-> EFFECTIVE_ADDRESS_O == WB_DATA_O)
      else $error("Pre-increment bit-reversed access differs from the new pointer.");
   a_brev_post_addr: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      BITREV_USED_O && $past(REQ_MODE_I) == AGMB_POST_INC
      |-> EFFECTIVE_ADDRESS_O == $past(REQ_WREG_I))
      else $error("Post-increment bit-reversed access did not use the old pointer.");
   a_brev_over_mod: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      BITREV_USED_O |-> !MOD_WRAP_O)
      else $error("Circular wrap applied to a bit-reversed write.");
   a_wrap_needs_en: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      MOD_WRAP_O |-> $past(MOD_ENABLE_I))
      else $error("Wrap reported with circular addressing off.");
   a_wb_sel_match: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      WB_VALID_O |-> WB_WSEL_O == $past(REQ_WSEL_I))
      else $error("Write-back aimed at the wrong register.");
   a_brev_inc_only: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && !is_inc |=> !BITREV_USED_O)
      else $error("Bit reversal used outside the increment forms.");
   a_up_no_wrap: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && is_inc && access_raw <= MOD_END_I && updated <= MOD_END_I |=> !MOD_WRAP_O)
      else $error("Incrementing access wrapped inside the upper boundary.");
   a_dn_no_wrap: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && is_dec && access_raw >= MOD_START_I && updated >= MOD_START_I |=> !MOD_WRAP_O)
      else $error("Decrementing access wrapped inside the lower boundary.");

   c_mod_wrap: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) MOD_WRAP_O);
   c_brev_used: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) BITREV_USED_O);
   c_base_ofs: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && REQ_MODE_I == AGMB_BASE_OFS && mod_hit);
   c_dn_wrap: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && is_dec && under_lo);
   c_brev_mod: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      REQ_VALID_I && brev_on && mod_hit);
endmodule
`default_nettype wire

// >>> agmb_mem_model.sv
// Purpose: Data-memory side model that logs accesses and keeps write-backs.
// Assumes: Access and write-back pulses last one cycle.
// Notes: The register file resets to zero.
`timescale 1ns/1ps
`default_nettype none
module agmb_mem_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic addr_valid_i,
   input wire logic [15:0] addr_i,
   input wire logic wb_valid_i,
   input wire logic [3:0] wb_wsel_i,
   input wire logic [15:0] wb_data_i
);
   logic [15:0] regs [16];
   logic [15:0] last_addr;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) regs[i] <= 16'h0000;
         last_addr <= 16'h0000;
      end else begin
         if (wb_valid_i) regs[wb_wsel_i] <= wb_data_i;
         if (addr_valid_i) last_addr <= addr_i;
      end
   end
endmodule
`default_nettype wire

// >>> agmb_top_tb.sv
// Purpose: Self-checking bench for the modulo and bit-reversed address generator.
// Assumes: One request per cycle, answer one cycle later.
// Notes: Random requests come from a fixed-seed xorshift.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module agmb_top_tb;
   import agmb_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, v = 1'b0, byt = 1'b0, wr = 1'b0, xa = 1'b0, men = 1'b0, ben = 1'b0;
   agmb_mode_t md = AGMB_DIRECT;
   logic [3:0] ws = 4'h0, mws = 4'h3, bws = 4'hF, wbs;
   logic [15:0] wreg = 16'h0000, ofs = 16'h0000, ms = 16'h2000, me = 16'h203F, bm = 16'h0000;
   logic av, wbv, bru, mwr, e_wbv, e_br, e_wr;
   logic [15:0] ea, wbd, e_ea, e_wb;
   logic [15:0] shadow [16];
   logic [31:0] seed = 32'hD4B9, r;
   int fail_count = 0, num_checks = 0;
   always #2.5 clk = ~clk;
   agmb_top u_agmb_top (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .REQ_VALID_I(v), .REQ_WSEL_I(ws),
      .REQ_MODE_I(md), .REQ_WREG_I(wreg), .REQ_OFFSET_I(ofs), .REQ_BYTE_I(byt), .REQ_WRITE_I(wr),
      .REQ_XAGU_I(xa), .MOD_ENABLE_I(men), .MOD_WSEL_I(mws), .MOD_START_I(ms), .MOD_END_I(me),
      .BITREV_ENABLE_BIT_I(ben), .BITREV_POINTER_SELECT_I(bws), .BITREV_MODIFIER_VALUE_I(bm),
      .ADDR_VALID_O(av), .EFFECTIVE_ADDRESS_O(ea), .WB_VALID_O(wbv), .WB_WSEL_O(wbs),
      .WB_DATA_O(wbd), .BITREV_USED_O(bru), .MOD_WRAP_O(mwr));
   agmb_mem_model u_agmb_mem_model (.clk_i(clk), .rst_n_i(rst_n), .addr_valid_i(av),
      .addr_i(ea), .wb_valid_i(wbv), .wb_wsel_i(wbs), .wb_data_i(wbd));
   function automatic logic [15:0] rev16(input logic [15:0] a);
      for (int i = 0; i < 16; i++) rev16[i] = a[15-i];
   endfunction
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic calc();
      logic [15:0] nw, len;
      len = me - ms + 16'h0001;
      case (md)
         AGMB_PRE_INC, AGMB_POST_INC: nw = wreg + (byt ? BYTE_STEP : WORD_STEP);
         AGMB_PRE_DEC, AGMB_POST_DEC: nw = wreg - (byt ? BYTE_STEP : WORD_STEP);
         AGMB_BASE_OFS: nw = wreg + ofs;
         default: nw = wreg;
      endcase
      e_wr = men && ws == mws && md != AGMB_DIRECT && (nw > me || nw < ms);
      if (e_wr) nw = (nw > me) ? nw - len : nw + len;
      e_br = ben && bws != STACK_SEL && ws == bws && wr && xa && !byt
         && (md == AGMB_PRE_INC || md == AGMB_POST_INC);
      if (e_br) nw = rev16(rev16(wreg) + rev16(bm)) & 16'hFFFE;
      if (e_br) e_wr = 1'b0;
      e_ea = (md == AGMB_PRE_INC || md == AGMB_PRE_DEC || md == AGMB_BASE_OFS) ? nw : wreg;
      e_wbv = md inside {AGMB_PRE_INC, AGMB_POST_INC, AGMB_PRE_DEC, AGMB_POST_DEC};
      e_wb = nw;
      if (e_wbv) shadow[ws] = nw;
   endtask
   task automatic go();
      v = 1'b1;
      calc();
      @(posedge clk);
      #1;
      `CHK("addr_valid", 1'b1, av)
      `CHK("address", e_ea, ea)
      `CHK("wb_valid", e_wbv, wbv)
      if (e_wbv) `CHK("wb_data", e_wb, wbd)
      if (e_wbv) `CHK("wb_wsel", ws, wbs)
      `CHK("bitrev_used", e_br, bru)
      `CHK("wrap", e_wr, mwr)
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #50000;
      fail_count++;
      close_out();
   end
   initial begin
      for (int i = 0; i < 16; i++) shadow[i] = 16'h0000;
      repeat (4) @(posedge clk);
      #1;
      `CHK("reset_out", 1'b0, av | wbv | bru | mwr)
      rst_n = 1'b1;
      md = AGMB_PRE_INC;
      wreg = 16'h1000;
      go();
      $display("test walk done");
      men = 1'b1;
      ws = 4'h3;
      ofs = 16'h0006;
      for (int i = 0; i < 6; i++) begin
         md = agmb_mode_t'(i);
         wreg = me - 16'h0001;
         go();
         wreg = ms;
         go();
      end
      $display("test boundary done");
      repeat (300) begin
         r = rnd();
         md = agmb_mode_t'(int'(r[2:0]) % 6);
         mws = r[12:9];
         ws = r[4] ? mws : r[8:5];
         bws = r[13] ? ws : 4'hF;
         {men, ben, byt, wr, xa} = r[18:14];
         wreg = ms + {10'h000, r[24:20], 1'b0};
         ofs = {12'h000, r[27:25], 1'b0};
         bm = {10'h000, r[31:28], 2'b00};
         go();
      end
      $display("test random done");
      v = 1'b0;
      @(posedge clk);
      #1;
      `CHK("idle", 1'b0, av | wbv)
      for (int i = 0; i < 16; i++) `CHK("reg_file", shadow[i], u_agmb_mem_model.regs[i])
      `CHK("last_addr", e_ea, u_agmb_mem_model.last_addr)
      close_out();
   end
endmodule
`default_nettype wire
